// *** hdl/mhc_sync2.sv ***
/*
 * Two-flip-flop synchroniser for a vector of asynchronous levels.
 * Assumes the inputs are independent levels from pins or other clocks.
 */
`timescale 1ns/1ps

module mhc_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // levels
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] q;
   } mhc_sync_state_t;

   mhc_sync_state_t st_r;
   mhc_sync_state_t st_nxt;

   // first stage is read only by the second stage
   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = d_i;
      st_nxt.q    = st_r.meta;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_o = st_r.q;

endmodule

// *** hdl/mhc_top.sv ***
/*
 * High-carrier select slice of a data signal modulator: control register
 * on Avalon-MM, source selection, polarity, output-disable and optional
 * synchronisation of a high-to-low carrier switch to the carrier's
 * falling edge.
 * Assumes pin and reference-clock inputs are asynchronous; the capture/
 * compare PWM outputs and the low carrier come from logic on clk_i.
 */
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

`include "mhc_cfg.svh"

module mhc_top (
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // avalon-mm slave
   input  wire logic [3:0]      avs_address_i,
   input  wire logic            avs_read_i,
   input  wire logic            avs_write_i,
   input  wire logic [31:0]     avs_writedata_i,
   input  wire logic [3:0]      avs_byteenable_i,
   output logic      [31:0]     avs_readdata_o,
   output logic                 avs_waitrequest_o,
   output logic [1:0]           avs_response_o,
   // carrier sources, same clock
   input  wire logic [3:0]      ccu_pwm_i,
   // carrier sources, asynchronous
   input  wire logic            reference_clock_output_i,
   input  wire logic            carrier_input_pin_one_i,
   input  wire logic            carrier_input_pin_two_i,
   // modulator side
   input  wire logic            low_carrier_i,
   input  wire logic            mod_data_i,
   output logic                 high_carrier_o,
   output logic                 mod_out_o,
   // per-source pin drive disables: [3:0] ccu one..four, [4] reference clock
   output logic [4:0]           src_out_disable_o,
   // control view
   output mhc_pkg::mhc_sel_t    high_carrier_source_select_o
);

   import mhc_pkg::*;

   typedef struct packed {
      logic [7:0]      ctrl;
      mhc_bus_state_t  bus;
      logic [31:0]     rdata;
      logic [1:0]      resp;
      logic            waitreq;
      logic            car_q;
      logic            car_prev;
      mhc_car_t        follow;
      logic            mod_out;
      logic [4:0]      odis;
   } mhc_state_t;

   mhc_state_t st_r;
   mhc_state_t st_nxt;

   logic [2:0] async_sync;
   logic       car_raw;
   logic       car_fall;

   // asynchronous sources pass two flip-flops before use
   mhc_sync2 #(
      .WIDTH(3)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i  ({carrier_input_pin_two_i, carrier_input_pin_one_i, reference_clock_output_i}),
      .q_o  (async_sync)
   );

   // source selector decode, used for carrier routing only; drive disables are decoded by odis_of
   function automatic logic pick(input logic [3:0] sel, input logic [3:0] pwm,
                                 input logic [2:0] asy);
      logic r;
      r = 1'b0;
      if (sel == `MHC_SEL_CCU4) begin
         r = pwm[3]; // RULE_10
      end else if (sel == `MHC_SEL_CCU3) begin
         r = pwm[2]; // RULE_13
      end else if (sel == `MHC_SEL_CCU2) begin
         r = pwm[1]; // RULE_13
      end else if (sel == `MHC_SEL_CCU1) begin
         r = pwm[0]; // RULE_13
      end else if (sel == `MHC_SEL_REFCLK) begin
         r = asy[0]; // RULE_12
      end else if (sel == `MHC_SEL_PIN2) begin
         r = asy[2]; // RULE_11
      end else if (sel == `MHC_SEL_PIN1) begin
         r = asy[1]; // RULE_13
      end else begin
         r = 1'b0; // RULE_09
      end
      return r;
   endfunction

   // one-hot drive disable for the selected peripheral
   function automatic logic [4:0] odis_of(input logic [3:0] sel, input logic dis);
      logic [4:0] r;
      r = 5'h00;
      if (dis) begin
         if (sel >= `MHC_SEL_CCU1 && sel <= `MHC_SEL_CCU4) begin
            r[sel[1:0]] = 1'b1;
         end else if (sel == `MHC_SEL_REFCLK) begin
            r[4] = 1'b1;
         end
      end
      return r;
   endfunction

   assign car_raw  = pick(st_r.ctrl[3:0], ccu_pwm_i, async_sync);
   assign car_fall = st_r.car_prev & ~st_r.car_q;

   // next state: bus slave, carrier conditioning, modulator switch
   always_comb begin
      st_nxt        = st_r;
      st_nxt.waitreq = 1'b1;
      case (st_r.bus)
         MHC_BUS_IDLE: begin
            if (avs_write_i || avs_read_i) begin
               st_nxt.bus    = MHC_BUS_ACK;
               st_nxt.waitreq = 1'b0;
               st_nxt.resp   = 2'h0;
               st_nxt.rdata  = 32'h0000_0000;
               if (avs_address_i == `MHC_OFS_CTRL) begin
                  if (avs_write_i && avs_byteenable_i[0]) begin
                     st_nxt.ctrl = avs_writedata_i[7:0] & `MHC_CTRL_WMASK; // RULE_07 RULE_08
                  end
                  st_nxt.rdata = {24'h00_0000, st_r.ctrl};
               end else if (avs_address_i == `MHC_OFS_STATUS) begin
                  st_nxt.rdata = {29'h0000_0000, st_r.follow, st_r.mod_out, st_r.car_q};
               end else begin
                  st_nxt.resp = 2'h2; // unmapped: slave error
               end
            end
         end
         MHC_BUS_ACK: begin
            st_nxt.bus = MHC_BUS_IDLE;
         end
         default: begin
            st_nxt.bus = MHC_BUS_IDLE;
         end
      endcase

      // polarity applied after selection
      st_nxt.car_q    = st_r.ctrl[`MHC_BIT_INV] ? ~car_raw : car_raw; // RULE_03 RULE_04
      st_nxt.car_prev = st_r.car_q;
      st_nxt.odis     = odis_of(st_r.ctrl[3:0], st_r.ctrl[`MHC_BIT_ODIS]); // RULE_01 RULE_02

      // carrier choice: high follows data=1; switch to low may wait for a fall
      if (mod_data_i) begin
         st_nxt.follow = MHC_CAR_HIGH;
      end else if (!st_r.ctrl[`MHC_BIT_SYNC] || car_fall) begin
         st_nxt.follow = MHC_CAR_LOW; // RULE_05 RULE_06
      end
      st_nxt.mod_out = (st_nxt.follow == MHC_CAR_HIGH) ? st_r.car_q : low_carrier_i;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r       <= '0;
         st_r.ctrl  <= `MHC_CTRL_RESET;
         st_r.waitreq <= 1'b1; // bus stalls while in reset
      end else begin
         st_r <= st_nxt;
      end
   end

   assign avs_readdata_o               = st_r.rdata;
   assign avs_waitrequest_o            = st_r.waitreq;
   assign avs_response_o               = st_r.resp;
   assign high_carrier_o               = st_r.car_q;
   assign mod_out_o                    = st_r.mod_out;
   assign src_out_disable_o            = st_r.odis;
   assign high_carrier_source_select_o = st_r.ctrl[3:0];

   // ---- checks ----
   sequence s_wr_ctrl;
      avs_write_i && !avs_waitrequest_o && avs_address_i == `MHC_OFS_CTRL
         && avs_byteenable_i[0];
   endsequence

   property p_unused_bit;
      @(posedge clk_i) disable iff (rst_i) st_r.ctrl[4] == 1'b0;
   endproperty
   a_unused_bit: assert property (p_unused_bit) else $error("bit 4 set"); // RULE_07

   property p_inv;
      @(posedge clk_i) disable iff (rst_i)
         ##1 st_r.ctrl[`MHC_BIT_INV] == $past(st_r.ctrl[`MHC_BIT_INV]) |->
         high_carrier_o == ($past(car_raw) ^ $past(st_r.ctrl[`MHC_BIT_INV]));
   endproperty
   a_inv: assert property (p_inv) else $error("polarity wrong"); // RULE_03

   property p_noinv;
      @(posedge clk_i) disable iff (rst_i)
         !st_r.ctrl[`MHC_BIT_INV] |=> high_carrier_o == $past(car_raw);
   endproperty
   a_noinv: assert property (p_noinv) else $error("carrier inverted"); // RULE_04

   property p_odis;
      @(posedge clk_i) disable iff (rst_i)
         st_r.ctrl[`MHC_BIT_ODIS] && st_r.ctrl[3:0] == `MHC_SEL_CCU4 |=>
         src_out_disable_o[3];
   endproperty
   a_odis: assert property (p_odis) else $error("drive not disabled"); // RULE_01

   property p_oen;
      @(posedge clk_i) disable iff (rst_i)
         !st_r.ctrl[`MHC_BIT_ODIS] |=> src_out_disable_o == 5'h00;
   endproperty
   a_oen: assert property (p_oen) else $error("drive wrongly disabled"); // RULE_02

   property p_sync_hold;
      @(posedge clk_i) disable iff (rst_i)
         st_r.follow == MHC_CAR_HIGH && st_r.ctrl[`MHC_BIT_SYNC] && !car_fall
         |=> st_r.follow == MHC_CAR_HIGH;
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("switch before fall"); // RULE_05

   property p_nosync;
      @(posedge clk_i) disable iff (rst_i)
         !mod_data_i && !st_r.ctrl[`MHC_BIT_SYNC] |=> st_r.follow == MHC_CAR_LOW;
   endproperty
   a_nosync: assert property (p_nosync) else $error("switch delayed"); // RULE_06

   property p_rsvd;
      @(posedge clk_i) disable iff (rst_i)
         st_r.ctrl[3:0] == `MHC_SEL_RSVD && !st_r.ctrl[`MHC_BIT_INV] ##1
         st_r.ctrl[3:0] == `MHC_SEL_RSVD && !st_r.ctrl[`MHC_BIT_INV] |-> !high_carrier_o;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved code drives carrier"); // RULE_09

   property p_sel_ccu4;
      @(posedge clk_i) disable iff (rst_i)
         st_r.ctrl[3:0] == `MHC_SEL_CCU4 |-> car_raw == ccu_pwm_i[3];
   endproperty
   a_sel_ccu4: assert property (p_sel_ccu4) else $error("unit four not routed"); // RULE_10

   property p_sel_wr;
      @(posedge clk_i) disable iff (rst_i)
         s_wr_ctrl |=> high_carrier_source_select_o == $past(avs_writedata_i[3:0]);
   endproperty
   a_sel_wr: assert property (p_sel_wr) else $error("selector not stored"); // RULE_08

   // a request taken while idle is answered on the next cycle
   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i)
         (avs_read_i || avs_write_i) && st_r.bus == MHC_BUS_IDLE |=> !avs_waitrequest_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("answer late"); // RULE_08

   // the answer stands for one cycle only
   property p_ack_short;
      @(posedge clk_i) disable iff (rst_i)
         !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_ack_short: assert property (p_ack_short) else $error("answer held too long"); // RULE_08

   // reference clock source gets its own drive disable
   property p_odis_ref;
      @(posedge clk_i) disable iff (rst_i)
         st_r.ctrl[`MHC_BIT_ODIS] && st_r.ctrl[3:0] == `MHC_SEL_REFCLK |=>
         src_out_disable_o == 5'h10;
   endproperty
   a_odis_ref: assert property (p_odis_ref) else $error("refclk drive not disabled"); // RULE_01

   // a carrier fall releases a held switch to the low carrier
   property p_sync_release;
      @(posedge clk_i) disable iff (rst_i)
         st_r.ctrl[`MHC_BIT_SYNC] && !mod_data_i && car_fall |=> st_r.follow == MHC_CAR_LOW;
   endproperty
   a_sync_release: assert property (p_sync_release) else $error("switch not released"); // RULE_05

   // data high puts the high carrier straight on the output
   property p_mod_high;
      @(posedge clk_i) disable iff (rst_i)
         mod_data_i |=> mod_out_o == $past(high_carrier_o);
   endproperty
   a_mod_high: assert property (p_mod_high) else $error("output not on high carrier"); // RULE_06

endmodule

// *** pkg/mhc_cfg.svh ***
/*
 * Constants for the high-carrier select slice: register offsets, field
 * positions, reset values and selector codes.
 * Assumes inclusion by bare name from the package and the design files.
 */
// Functional notes
// [RULE_01] out-disable bit set: selected source peripheral stops driving its pin.
// [RULE_02] out-disable bit clear: selected source peripheral drives its pin normally.
// [RULE_03] invert bit set: selected high carrier is inverted before use.
// [RULE_04] invert bit clear: selected high carrier passes uninverted.
// [RULE_05] sync bit set: switch high to low waits for carrier falling edge.
// [RULE_06] sync bit clear: modulator output follows data with no edge alignment.
// [RULE_07] bit 4 of the control register reads zero, writes ignored.
// [RULE_08] four-bit source selector in bits 3..0 picks the high carrier.
// [RULE_09] selector code 1111 is reserved, no carrier connected.
// [RULE_10] code 0111 routes capture/compare unit four PWM output.
// [RULE_11] code 0010 routes carrier input pin two.
// [RULE_12] reference clock output is one selectable high carrier source.
// [RULE_13] 0110/0101/0100 units three/two/one; 0011 refclk; 0001 pin one; 0000 low.
`ifndef MHC_CFG_SVH
`define MHC_CFG_SVH

`define MHC_OFS_CTRL      4'h0
`define MHC_OFS_STATUS    4'h4
`define MHC_CTRL_RESET    8'h00
`define MHC_BIT_ODIS      7
`define MHC_BIT_INV       6
`define MHC_BIT_SYNC      5
`define MHC_CTRL_WMASK    8'hEF
`define MHC_SEL_LOW       4'h0
`define MHC_SEL_PIN1      4'h1
`define MHC_SEL_PIN2      4'h2
`define MHC_SEL_REFCLK    4'h3
`define MHC_SEL_CCU1      4'h4
`define MHC_SEL_CCU2      4'h5
`define MHC_SEL_CCU3      4'h6
`define MHC_SEL_CCU4      4'h7
`define MHC_SEL_RSVD      4'hF

`endif

// *** pkg/mhc_pkg.sv ***
/*
 * Types for the high-carrier select slice.
 * Assumes mhc_cfg.svh is on the include path.
 */
`include "mhc_cfg.svh"

package mhc_pkg;

   typedef logic [3:0] mhc_sel_t;

   // bus transaction phase
   typedef enum logic [1:0] {
      MHC_BUS_IDLE,
      MHC_BUS_ACK
   } mhc_bus_state_t;

   // which carrier the modulator currently follows
   typedef enum logic {
      MHC_CAR_LOW,
      MHC_CAR_HIGH
   } mhc_car_t;

endpackage

// *** verif/mhc_src_model.sv ***
/*
 * Stand-in for the carrier source peripherals and carrier input pins.
 * Assumes the bench requests the wanted source levels on lvl_i.
 */
`timescale 1ns/1ps

module mhc_src_model (
   // clock and level request
   input  wire logic       clk_i,
   input  wire logic [6:0] lvl_i,
   // sources: [3:0] pwm units one..four, [4] refclk, [5] pin one, [6] pin two
   output logic [3:0]      ccu_pwm_o,
   output logic            refclk_o,
   output logic            pin_one_o,
   output logic            pin_two_o
);
   // pwm units are logic on the same clock
   always @(posedge clk_i) begin
      ccu_pwm_o <= lvl_i[3:0];
   end
   // pins and reference clock move off the clock grid
   initial {pin_two_o, pin_one_o, refclk_o} = 3'b000;
   always @(lvl_i) begin
      #7 {pin_two_o, pin_one_o, refclk_o} = lvl_i[6:4];
   end
endmodule

// *** verif/test_modulator_high_carrier_select.sv ***
/*
 * Self-checking bench for the high-carrier select slice.
 * Assumes mhc_cfg.svh on the include path and the source stand-in model.
 */
`timescale 1ns/1ps
`include "mhc_cfg.svh"

module test_modulator_high_carrier_select;
   import mhc_pkg::*;
   typedef struct packed {logic [7:0] ctrl; logic [6:0] pat; logic hc; logic [4:0] dis;} mhc_row_t;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [3:0]  adr = 4'h0;
   logic [3:0]  be = 4'h0;
   logic        rd_en = 1'b0;
   logic        wr_en = 1'b0;
   logic        low_car = 1'b0;
   logic        mdat = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [6:0]  lvl = 7'h00;
   logic [31:0] rdat, rd_o;
   logic [1:0]  rsp, rsp_o;
   logic [3:0]  pwm;
   logic        wait_o, refclk, pin1, pin2, hc, mo;
   logic [4:0]  dis;
   mhc_sel_t    sel;
   int          err_count = 0;
   int          checked = 0;
   mhc_row_t    rows [25] = '{
      '{8'h00, 7'h7F, 1'b0, 5'h00},
      '{8'h01, 7'h20, 1'b1, 5'h00},
      '{8'h01, 7'h5F, 1'b0, 5'h00},
      '{8'h02, 7'h40, 1'b1, 5'h00},
      '{8'h02, 7'h3F, 1'b0, 5'h00},
      '{8'h03, 7'h10, 1'b1, 5'h00},
      '{8'h13, 7'h6F, 1'b0, 5'h00},
      '{8'h04, 7'h01, 1'b1, 5'h00},
      '{8'h05, 7'h02, 1'b1, 5'h00},
      '{8'h06, 7'h04, 1'b1, 5'h00},
      '{8'h07, 7'h08, 1'b1, 5'h00},
      '{8'h07, 7'h77, 1'b0, 5'h00},
      '{8'h0F, 7'h7F, 1'b0, 5'h00},
      '{8'h8F, 7'h7F, 1'b0, 5'h00},
      '{8'h0A, 7'h7F, 1'b0, 5'h00},
      '{8'h47, 7'h08, 1'b0, 5'h00},
      '{8'h47, 7'h00, 1'b1, 5'h00},
      '{8'h40, 7'h00, 1'b1, 5'h00},
      '{8'h87, 7'h08, 1'b1, 5'h08},
      '{8'h83, 7'h10, 1'b1, 5'h10},
      '{8'h84, 7'h00, 1'b0, 5'h01},
      '{8'h85, 7'h00, 1'b0, 5'h02},
      '{8'h86, 7'h00, 1'b0, 5'h04},
      '{8'hC1, 7'h20, 1'b0, 5'h00},
      '{8'h06, 7'h04, 1'b1, 5'h00}
   };

   // clock
   always #12.5 clk_i = ~clk_i;

   mhc_src_model mhc_src_model_i (
      .clk_i(clk_i), .lvl_i(lvl), .ccu_pwm_o(pwm),
      .refclk_o(refclk), .pin_one_o(pin1), .pin_two_o(pin2)
   );

   mhc_top mhc_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd_en),
      .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rd_o), .avs_waitrequest_o(wait_o), .avs_response_o(rsp_o),
      .ccu_pwm_i(pwm), .reference_clock_output_i(refclk), .carrier_input_pin_one_i(pin1),
      .carrier_input_pin_two_i(pin2), .low_carrier_i(low_car), .mod_data_i(mdat),
      .high_carrier_o(hc), .mod_out_o(mo), .src_out_disable_o(dis),
      .high_carrier_source_select_o(sel)
   );

   // compare one result
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] b);
      @(posedge clk_i);
      adr <= a;
      wr_en <= wr;
      rd_en <= !wr;
      wdat <= {24'h0, d};
      be <= b;
      do begin
         @(posedge clk_i);
      end while (wait_o !== 1'b0);
      rdat = rd_o;
      rsp = rsp_o;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask

   // verdict and end of run
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (5000) @(posedge clk_i);
      err_count++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      chk("waitrequest_in_reset", 1, wait_o);
      chk("disable_in_reset", 0, dis);
      rst_i <= 1'b0;
      bus(0, `MHC_OFS_CTRL, 8'h00, 4'hF);
      chk("ctrl_reset", {24'h0, `MHC_CTRL_RESET}, rdat);
      foreach (rows[i]) begin
         lvl <= rows[i].pat;
         bus(1, `MHC_OFS_CTRL, rows[i].ctrl, 4'hF);
         repeat (6) @(posedge clk_i);
         chk("high_carrier", rows[i].hc, hc);
         chk("out_disable", rows[i].dis, dis);
         chk("select", rows[i].ctrl[3:0], sel);
         bus(0, `MHC_OFS_CTRL, 8'h00, 4'hF);
         chk("ctrl_read", rows[i].ctrl & `MHC_CTRL_WMASK, rdat);
      end
      // byte lane 0 off, then unmapped write and read
      bus(1, `MHC_OFS_CTRL, 8'hFF, 4'h0);
      bus(1, 4'h8, 8'hFF, 4'hF);
      bus(0, `MHC_OFS_CTRL, 8'h00, 4'hF);
      chk("ctrl_kept", 32'h06, rdat);
      bus(0, 4'h8, 8'h00, 4'hF);
      chk("unmapped_resp", 2'b10, rsp);
      chk("unmapped_data", 0, rdat);
      // synchronised switch waits for the carrier falling edge
      lvl <= 7'h01;
      mdat <= 1'b1;
      bus(1, `MHC_OFS_CTRL, 8'h24, 4'hF);
      repeat (6) @(posedge clk_i);
      chk("mod_out_high", 1, mo);
      mdat <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("mod_out_held", 1, mo);
      lvl <= 7'h00;
      low_car <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("mod_out_low", 1, mo);
      bus(0, `MHC_OFS_STATUS, 8'h00, 4'hF);
      chk("status", 32'h2, rdat);
      // free switch without alignment
      lvl <= 7'h01;
      low_car <= 1'b0;
      mdat <= 1'b1;
      bus(1, `MHC_OFS_CTRL, 8'h04, 4'hF);
      repeat (6) @(posedge clk_i);
      chk("mod_out_free_high", 1, mo);
      mdat <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("mod_out_free_low", 0, mo);
      // reset in mid-run
      bus(1, `MHC_OFS_CTRL, 8'hE7, 4'hF);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("select_after_reset", 0, sel);
      bus(0, `MHC_OFS_CTRL, 8'h00, 4'hF);
      chk("ctrl_after_reset", {24'h0, `MHC_CTRL_RESET}, rdat);
      tally_and_finish();
   end
endmodule
